//--- src/frame_fifo_reset_monitor.sv
`timescale 1ns/100ps
`default_nettype none
// How it works
// - free-running periodic frame or single pulse both serve as reset source
// - continuous mode repositions pointers on every valid frame pulse
// - one-shot mode acts on first valid pulse after control write, then ignores
// - one control bit picks continuous or one-shot; one-shot after reset
// - requested level resets to 0x40
// - completed frame reset sets a readable acknowledge bit
// - readback lands within one core cycle of request and holds
// - readback shows current depth in the request's integral/fractional format
// - three status bits flag collision and near-collision of pointers
// - enabled status bits latch and drive two active-low interrupts
// - request holds integral level in bits 6:4, fractional in 2:0
// - equal write and read slots of the eight-slot fifo is a fault
module frame_fifo_reset_monitor #(
    parameter int DEPTH = 8
) (
    // core clock, reset and freeze
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic clk_en,
    // register access
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    output logic [7:0] reg_rdata,
    // link side
    input wire logic input_data_clock,
    input wire logic frame_in,
    input wire logic byte_mode,
    input wire logic [15:0] data_i,
    input wire logic [15:0] data_q,
    // samples toward the datapath
    output logic [15:0] sample_i,
    output logic [15:0] sample_q,
    output logic sample_valid,
    // interrupts
    output logic interrupt_out_a_n,
    output logic interrupt_out_b_n
);
    typedef struct packed {
        logic [2:0] en_a;
        logic [2:0] en_b;
        logic [2:0] status;
        logic [1:0] mode;
        logic cont;
        logic ack;
        logic [7:0] level_req;
        logic [1:0] interp;
        frame_fifo_pkg::oneshot_e oneshot;
        logic [2:0] rptr;
        logic [2:0] phase;
        logic tog_seen;
        logic [7:0] rdata;
        logic [15:0] sample_i;
        logic [15:0] sample_q;
        logic sample_valid;
        logic irq_a_n;
        logic irq_b_n;
    } core_s;

    core_s st_r;
    core_s st_nxt;
    logic [1:0] rst_pipe_r;
    logic rst_core_n;
    logic [2:0] wptr_gray_link;
    logic [2:0] wptr_gray_sync;
    logic frame_toggle_link;
    logic frame_toggle_sync;
    logic [15:0] rd_data_i;
    logic [15:0] rd_data_q;
    logic [2:0] wbin;
    logic [2:0] depth;
    logic [2:0] phase_last;
    logic [2:0] raw_flags;
    logic frame_event;
    logic take_reset;
    logic ctrl_write;

    initial begin
        if (DEPTH != 8) begin
            $error("level fields are three bits wide, depth must be eight");
        end
    end

    // reset release through two flops on the core clock
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rst_pipe_r <= 2'h0;
        end else begin
            rst_pipe_r <= {rst_pipe_r[0], 1'b1};
        end
    end
    assign rst_core_n = rst_pipe_r[1];

    // write side and frame qualification live on the link clock
    frame_link_side #(.DEPTH(DEPTH)) link_u (
        .input_data_clock(input_data_clock),
        .rstn(rstn),
        .byte_mode(byte_mode),
        .frame_in(frame_in),
        .data_i(data_i),
        .data_q(data_q),
        .rd_addr(st_r.rptr),
        .wptr_gray(wptr_gray_link),
        .frame_toggle(frame_toggle_link),
        .rd_data_i(rd_data_i),
        .rd_data_q(rd_data_q)
    );

    // gray pointer: one bit moves per step, so a word crossing is safe
    cdc_sync #(.WIDTH(3)) wptr_sync_u (
        .clk(ref_clk),
        .rst_n(rst_core_n),
        .en(clk_en),
        .async_in(wptr_gray_link),
        .sync_out(wptr_gray_sync)
    );

    // request event crosses as a toggle
    cdc_sync #(.WIDTH(1)) frame_sync_u (
        .clk(ref_clk),
        .rst_n(rst_core_n),
        .en(clk_en),
        .async_in(frame_toggle_link),
        .sync_out(frame_toggle_sync)
    );

    // gray to binary, depth and pointer flags
    always_comb begin
        wbin[2] = wptr_gray_sync[2];
        wbin[1] = wbin[2] ^ wptr_gray_sync[1];
        wbin[0] = wbin[1] ^ wptr_gray_sync[0];
        depth = wbin - st_r.rptr;
        raw_flags = '0;
        raw_flags[frame_fifo_pkg::STATUS_COLLIDE_BIT] = (depth == 3'h0);
        raw_flags[frame_fifo_pkg::STATUS_NEAR_FULL_BIT] = (depth == 3'(DEPTH - 1));
        raw_flags[frame_fifo_pkg::STATUS_NEAR_EMPTY_BIT] = (depth == 3'h1);
        unique case (st_r.interp)
            2'h0: phase_last = frame_fifo_pkg::PHASE_LAST_2X;
            2'h1: phase_last = frame_fifo_pkg::PHASE_LAST_4X;
            2'h2: phase_last = frame_fifo_pkg::PHASE_LAST_8X;
            2'h3: phase_last = frame_fifo_pkg::PHASE_LAST_8X;
        endcase
    end

    // a frame request counts only in fifo mode, and in one-shot only when armed
    assign frame_event = frame_toggle_sync != st_r.tog_seen;
    assign take_reset = frame_event && st_r.mode == frame_fifo_pkg::FRAME_MODE_FIFO
        && (st_r.cont || st_r.oneshot == frame_fifo_pkg::ONESHOT_ARMED);
    assign ctrl_write = reg_write && reg_addr == frame_fifo_pkg::ADDR_FRAME_CTRL;

    // whole core state; register writes first so hardware sets win
    always_comb begin
        st_nxt = st_r;
        st_nxt.tog_seen = frame_toggle_sync;
        st_nxt.sample_valid = 1'b0;
        // read pointer steps at the data rate, core clock / interpolation
        if (st_r.phase == 3'h0) begin
            st_nxt.phase = phase_last;
            st_nxt.rptr = st_r.rptr + 3'h1;
            st_nxt.sample_i = rd_data_i;
            st_nxt.sample_q = rd_data_q;
            st_nxt.sample_valid = 1'b1;
        end else begin
            st_nxt.phase = st_r.phase - 3'h1;
        end
        if (reg_write) begin
            unique case (reg_addr)
                frame_fifo_pkg::ADDR_IRQ_EN_A: st_nxt.en_a = reg_wdata[2:0];
                frame_fifo_pkg::ADDR_IRQ_EN_B: st_nxt.en_b = reg_wdata[2:0];
                frame_fifo_pkg::ADDR_STATUS: st_nxt.status = st_r.status & ~reg_wdata[2:0];
                frame_fifo_pkg::ADDR_FRAME_CTRL: begin
                    st_nxt.mode = reg_wdata[frame_fifo_pkg::CTRL_MODE_LSB +: 2];
                    st_nxt.cont = reg_wdata[frame_fifo_pkg::CTRL_CONT_BIT];
                    st_nxt.ack = 1'b0;
                    st_nxt.oneshot = frame_fifo_pkg::ONESHOT_ARMED;
                end
                frame_fifo_pkg::ADDR_LEVEL_REQ: begin
                    st_nxt.level_req = reg_wdata & frame_fifo_pkg::LEVEL_REQ_MASK;
                end
                frame_fifo_pkg::ADDR_INTERP: st_nxt.interp = reg_wdata[1:0];
                default: begin
                end
            endcase
        end
        // frame reset: place read pointer behind write pointer by the request
        if (take_reset) begin
            st_nxt.rptr = wbin - st_r.level_req[frame_fifo_pkg::LEVEL_INT_LSB +: 3];
            st_nxt.phase = st_r.level_req[frame_fifo_pkg::LEVEL_FRAC_LSB +: 3];
            st_nxt.sample_valid = 1'b0;
            st_nxt.ack = 1'b1;
            st_nxt.oneshot = frame_fifo_pkg::ONESHOT_IDLE;
        end
        // latch flags enabled for either interrupt; set beats a clear
        st_nxt.status = st_nxt.status | (raw_flags & (st_r.en_a | st_r.en_b));
        st_nxt.irq_a_n = ~|(st_nxt.status & st_nxt.en_a);
        st_nxt.irq_b_n = ~|(st_nxt.status & st_nxt.en_b);
        // registered read data, no read side effects
        unique case (reg_addr)
            frame_fifo_pkg::ADDR_IRQ_EN_A: st_nxt.rdata = {5'h0, st_r.en_a};
            frame_fifo_pkg::ADDR_IRQ_EN_B: st_nxt.rdata = {5'h0, st_r.en_b};
            frame_fifo_pkg::ADDR_STATUS: st_nxt.rdata = {1'b0, raw_flags, 1'b0, st_r.status};
            frame_fifo_pkg::ADDR_FRAME_CTRL: st_nxt.rdata = {4'h0, st_r.ack, st_r.cont,
                                                             st_r.mode};
            frame_fifo_pkg::ADDR_LEVEL_REQ: st_nxt.rdata = st_r.level_req;
            frame_fifo_pkg::ADDR_LEVEL_RB: st_nxt.rdata = {1'b0, depth, 1'b0,
                                                           st_r.phase};
            frame_fifo_pkg::ADDR_INTERP: st_nxt.rdata = {6'h0, st_r.interp};
            default: st_nxt.rdata = 8'h00;
        endcase
    end

    // one register for all state; clk_en low freezes it
    always_ff @(posedge ref_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            st_r <= '0;
            st_r.mode <= frame_fifo_pkg::FRAME_MODE_RESET;
            st_r.cont <= frame_fifo_pkg::CONT_RESET;
            st_r.level_req <= frame_fifo_pkg::LEVEL_REQ_RESET;
            st_r.interp <= frame_fifo_pkg::INTERP_RESET;
            st_r.en_a <= frame_fifo_pkg::IRQ_EN_RESET;
            st_r.en_b <= frame_fifo_pkg::IRQ_EN_RESET;
            st_r.oneshot <= frame_fifo_pkg::ONESHOT_IDLE;
            st_r.irq_a_n <= 1'b1;
            st_r.irq_b_n <= 1'b1;
        end else if (clk_en) begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata = st_r.rdata;
    assign sample_i = st_r.sample_i;
    assign sample_q = st_r.sample_q;
    assign sample_valid = st_r.sample_valid;
    assign interrupt_out_a_n = st_r.irq_a_n;
    assign interrupt_out_b_n = st_r.irq_b_n;

    // helper: high from the second cycle after reset release
    logic seen_r;
    always_ff @(posedge ref_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            seen_r <= 1'b0;
        end else begin
            seen_r <= 1'b1;
        end
    end

    default clocking core_cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_core_n);

    sequence reset_taken_s;
        clk_en && take_reset;
    endsequence

    level_default_a: assert property (!seen_r |-> st_r.level_req == 8'h40)
        else $error("requested level not 0x40 after reset");

    oneshot_default_a: assert property (!seen_r |-> !st_r.cont && !take_reset)
        else $error("device left reset outside one-shot mode");

    reset_ack_a: assert property (reset_taken_s |=> st_r.ack
        && st_r.phase == $past(st_r.level_req[2:0]))
        else $error("frame reset did not set acknowledge and fraction");

    level_place_a: assert property (reset_taken_s |=>
        st_r.rptr == $past(wbin) - $past(st_r.level_req[6:4]))
        else $error("read pointer not placed by requested level");

    cont_repeat_a: assert property (clk_en && frame_event && st_r.cont && !ctrl_write
        && st_r.mode == 2'h0 |=> st_r.ack)
        else $error("continuous mode skipped a frame pulse");

    oneshot_ignore_a: assert property (clk_en && frame_event && !st_r.cont && !ctrl_write
        && st_r.oneshot == frame_fifo_pkg::ONESHOT_IDLE |=> $stable(st_r.ack))
        else $error("one-shot mode acted on a later pulse");

    mode_gate_a: assert property (clk_en && frame_event && st_r.mode != 2'h0
        && !ctrl_write |=> $stable(st_r.rptr) || st_r.rptr == $past(st_r.rptr) + 3'h1)
        else $error("frame moved pointers outside fifo mode");

    readback_a: assert property (clk_en && reg_addr == 8'h24 |=>
        reg_rdata == {1'b0, $past(depth), 1'b0, $past(st_r.phase)})
        else $error("level readback does not show current depth");

    collide_latch_a: assert property (clk_en && depth == 3'h0 && st_r.en_a[0]
        |=> st_r.status[0] ##1 !clk_en || st_r.status[0] || $past(reg_write))
        else $error("pointer collision was not latched");

    irq_drive_a: assert property (clk_en && (st_nxt.status & st_nxt.en_b) != 3'h0
        |=> !interrupt_out_b_n)
        else $error("enabled status did not pull interrupt low");
endmodule
`default_nettype wire

//--- src/frame_fifo_pkg.sv
`default_nettype none
package frame_fifo_pkg;
    // register offsets
    localparam logic [7:0] ADDR_IRQ_EN_A = 8'h03;
    localparam logic [7:0] ADDR_IRQ_EN_B = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h06;
    localparam logic [7:0] ADDR_FRAME_CTRL = 8'h22;
    localparam logic [7:0] ADDR_LEVEL_REQ = 8'h23;
    localparam logic [7:0] ADDR_LEVEL_RB = 8'h24;
    localparam logic [7:0] ADDR_INTERP = 8'h28;

    // field positions
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_CONT_BIT = 2;
    localparam int CTRL_ACK_BIT = 3;
    localparam int LEVEL_INT_LSB = 4;
    localparam int LEVEL_FRAC_LSB = 0;
    localparam int STATUS_COLLIDE_BIT = 0;
    localparam int STATUS_NEAR_FULL_BIT = 1;
    localparam int STATUS_NEAR_EMPTY_BIT = 2;
    localparam int STATUS_LIVE_LSB = 4;

    // values after reset and field codes
    localparam logic [7:0] LEVEL_REQ_RESET = 8'h40;
    localparam logic [7:0] LEVEL_REQ_MASK = 8'h77;
    localparam logic [1:0] FRAME_MODE_RESET = 2'h3;
    localparam logic [1:0] FRAME_MODE_FIFO = 2'h0;
    localparam logic CONT_RESET = 1'b0;
    localparam logic [1:0] INTERP_RESET = 2'h0;
    localparam logic [2:0] IRQ_EN_RESET = 3'h0;

    // last phase of the read divider per interpolation code (2x, 4x, 8x, 8x)
    localparam logic [2:0] PHASE_LAST_2X = 3'h1;
    localparam logic [2:0] PHASE_LAST_4X = 3'h3;
    localparam logic [2:0] PHASE_LAST_8X = 3'h7;

    // least frame high time in input data clock cycles
    localparam logic [1:0] WORD_MIN_CYCLES = 2'h1;
    localparam logic [1:0] BYTE_MIN_CYCLES = 2'h2;

    typedef enum logic {ONESHOT_IDLE, ONESHOT_ARMED} oneshot_e;
endpackage
`default_nettype wire

//--- src/cdc_sync.sv
`timescale 1ns/100ps
`default_nettype none
module cdc_sync #(
    parameter int WIDTH = 1
) (
    // clocking
    input wire logic clk,
    input wire logic rst_n,
    input wire logic en,
    // crossing
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] held;
    } sync_s;

    sync_s st_r;
    sync_s st_nxt;

    initial begin
        if (WIDTH < 1) begin
            $error("cdc_sync width must be at least one");
        end
    end

    // three stages; a new value counts once stages two and three agree
    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = async_in;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        if (st_r.s2 == st_r.s3) begin
            st_nxt.held = st_r.s3;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else if (en) begin
            st_r <= st_nxt;
        end
    end

    assign sync_out = st_r.held;

    held_agree_a: assert property (@(posedge clk) disable iff (!rst_n)
        $changed(st_r.held) |-> $past(st_r.s2) == $past(st_r.s3))
        else $error("synchroniser took a value before two stages agreed");
endmodule
`default_nettype wire

//--- src/frame_link_side.sv
`timescale 1ns/100ps
`default_nettype none
module frame_link_side #(
    parameter int DEPTH = 8
) (
    // link clock and raw reset
    input wire logic input_data_clock,
    input wire logic rstn,
    // link pins
    input wire logic byte_mode,
    input wire logic frame_in,
    input wire logic [15:0] data_i,
    input wire logic [15:0] data_q,
    // toward the core domain
    input wire logic [2:0] rd_addr,
    output logic [2:0] wptr_gray,
    output logic frame_toggle,
    output logic [15:0] rd_data_i,
    output logic [15:0] rd_data_q
);
    typedef struct packed {
        logic [2:0] wptr;
        logic [2:0] wgray;
        logic frame_d;
        logic [1:0] high_cnt;
        logic toggle;
    } link_s;

    link_s st_r;
    link_s st_nxt;
    logic [1:0] rst_pipe_r;
    logic link_rst_n;
    logic byte_mode_sync;
    logic [1:0] min_cycles;
    logic [31:0] mem_r [DEPTH];

    initial begin
        if (DEPTH != 8) begin
            $error("level fields are three bits wide, depth must be eight");
        end
    end

    // reset release on the link clock
    always_ff @(posedge input_data_clock or negedge rstn) begin
        if (!rstn) begin
            rst_pipe_r <= 2'h0;
        end else begin
            rst_pipe_r <= {rst_pipe_r[0], 1'b1};
        end
    end
    assign link_rst_n = rst_pipe_r[1];

    // byte mode is a static strap from outside this domain
    cdc_sync #(.WIDTH(1)) byte_mode_sync_u (
        .clk(input_data_clock),
        .rst_n(link_rst_n),
        .en(1'b1),
        .async_in(byte_mode),
        .sync_out(byte_mode_sync)
    );

    assign min_cycles = byte_mode_sync ? frame_fifo_pkg::BYTE_MIN_CYCLES
                                       : frame_fifo_pkg::WORD_MIN_CYCLES;

    // frame is source synchronous: one sample, count high cycles, act on the fall
    always_comb begin
        st_nxt = st_r;
        st_nxt.frame_d = frame_in;
        if (frame_in) begin
            st_nxt.high_cnt = (st_r.high_cnt == 2'h3) ? st_r.high_cnt : st_r.high_cnt + 2'h1;
        end else begin
            st_nxt.high_cnt = 2'h0;
        end
        // only a full low-high-low pulse of the least width is a request
        if (st_r.frame_d && !frame_in && st_r.high_cnt >= min_cycles) begin
            st_nxt.toggle = ~st_r.toggle;
        end
        st_nxt.wptr = st_r.wptr + 3'h1;
        st_nxt.wgray = st_nxt.wptr ^ (st_nxt.wptr >> 1);
    end

    always_ff @(posedge input_data_clock or negedge link_rst_n) begin
        if (!link_rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // one word per link clock; the core reads the slot it points at
    always_ff @(posedge input_data_clock) begin
        mem_r[st_r.wptr] <= {data_i, data_q};
    end

    assign wptr_gray = st_r.wgray;
    assign frame_toggle = st_r.toggle;
    assign rd_data_i = mem_r[rd_addr][31:16];
    assign rd_data_q = mem_r[rd_addr][15:0];

    sequence frame_fall_s;
        st_r.frame_d && !frame_in;
    endsequence

    short_pulse_a: assert property (@(posedge input_data_clock) disable iff (!link_rst_n)
        frame_fall_s and (st_r.high_cnt < min_cycles) |=> $stable(st_r.toggle))
        else $error("too short frame pulse was taken as a reset request");

    valid_pulse_a: assert property (@(posedge input_data_clock) disable iff (!link_rst_n)
        frame_fall_s and (st_r.high_cnt >= min_cycles) |=> st_r.toggle != $past(st_r.toggle))
        else $error("valid frame pulse was not passed on");

    wptr_step_a: assert property (@(posedge input_data_clock) disable iff (!link_rst_n)
        1'b1 |=> st_r.wptr == $past(st_r.wptr) + 3'h1)
        else $error("write pointer missed a step");
endmodule
`default_nettype wire

//--- testbench/frame_source.sv
`timescale 1ns/100ps
`default_nettype none
module frame_source (
    // link pins
    output logic input_data_clock,
    output logic frame_in,
    output logic [15:0] data_i,
    output logic [15:0] data_q,
    // free-running frame select
    input wire logic periodic
);
    // link clock runs free, both clocks stable before any reset
    initial begin
        input_data_clock = 1'b0;
        #3.7;
        forever #7.5 input_data_clock = ~input_data_clock;
    end
    initial begin
        frame_in = 1'b0;
        data_i = 16'h0000;
        data_q = 16'hffff;
    end
    // one i/q word pair per link edge
    always @(posedge input_data_clock) begin
        data_i <= data_i + 16'h0001;
        data_q <= data_q - 16'h0001;
    end
    // low-high-low frame held n link periods
    task automatic pulse(input int n);
        @(posedge input_data_clock);
        frame_in <= 1'b1;
        repeat (n) @(posedge input_data_clock);
        frame_in <= 1'b0;
    endtask
    // periodic frame; the gap lets the core count each pulse
    always begin
        @(posedge input_data_clock);
        if (periodic) begin
            pulse(2);
            repeat (10) @(posedge input_data_clock);
        end
    end
endmodule
`default_nettype wire

//--- testbench/tb_frame_fifo_reset_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module tb_frame_fifo_reset_monitor;
    logic ref_clk, rstn, clk_en, reg_write, byte_mode, periodic;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, v;
    logic input_data_clock, frame_in, interrupt_out_a_n, interrupt_out_b_n;
    logic [15:0] data_i, data_q;
    logic sample_valid;
    int num_errors, checks_done, n;

    frame_fifo_reset_monitor #(.DEPTH(8)) dut (.ref_clk(ref_clk), .rstn(rstn), .clk_en(clk_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_rdata(reg_rdata), .input_data_clock(input_data_clock), .frame_in(frame_in),
        .byte_mode(byte_mode), .data_i(data_i), .data_q(data_q), .sample_i(), .sample_q(),
        .sample_valid(sample_valid), .interrupt_out_a_n(interrupt_out_a_n),
        .interrupt_out_b_n(interrupt_out_b_n));
    frame_source src (.input_data_clock(input_data_clock), .frame_in(frame_in),
        .data_i(data_i), .data_q(data_q), .periodic(periodic));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic end_of_test;
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge ref_clk);
        reg_write <= 1'b0;
    endtask

    // read data stands one edge after the address is taken
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk);
        reg_addr <= a;
        @(posedge ref_clk);
        #1;
        v = reg_rdata;
    endtask

    task automatic wait_ack;
        for (int i = 0; i < 20; i++) begin
            rd(frame_fifo_pkg::ADDR_FRAME_CTRL);
            if (v[3] === 1'b1) break;
        end
        chk("frame ack", 8'h08, v & 8'h08);
    endtask

    // level in core cycles at 2x; up to two core cycles either way allowed since link and read rates differ
    function automatic logic [7:0] near(input logic [7:0] rb);
        int d;
        d = (rb[6:4] * 2 + rb[2:0]) - 9;
        return {7'h00, (d >= -2 && d <= 2)};
    endfunction

    // reset, then a second pulse after the depth has drifted well away
    task automatic two_pulse(input logic [7:0] ctrl, input logic [7:0] exp);
        wr(frame_fifo_pkg::ADDR_FRAME_CTRL, ctrl);
        src.pulse(2);
        wait_ack;
        rd(frame_fifo_pkg::ADDR_LEVEL_RB);
        chk("level after reset", 8'h01, near(v));
        repeat (12) @(posedge ref_clk);
        src.pulse(2);
        repeat (6) @(posedge ref_clk);
        rd(frame_fifo_pkg::ADDR_LEVEL_RB);
        chk("level after second pulse", exp, near(v));
    endtask

    initial begin
        rstn = 1'b0;
        clk_en = 1'b1;
        reg_write = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        byte_mode = 1'b0;
        periodic = 1'b0;
        num_errors = 0;
        checks_done = 0;
        v = 8'h00;
        repeat (20) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (5) @(posedge ref_clk);
        // values after reset and an unmapped place
        rd(frame_fifo_pkg::ADDR_FRAME_CTRL);
        chk("frame control", 8'h03, v);
        rd(frame_fifo_pkg::ADDR_LEVEL_REQ);
        chk("level request", 8'h40, v);
        // a write offered while the core is frozen must not land
        clk_en <= 1'b0;
        wr(frame_fifo_pkg::ADDR_LEVEL_REQ, 8'h12);
        clk_en <= 1'b1;
        rd(frame_fifo_pkg::ADDR_LEVEL_REQ);
        chk("frozen write", 8'h40, v);
        wr(8'h10, 8'hff);
        rd(8'h10);
        chk("unmapped", 8'h00, v);
        // a pulse with the mode field still at its reset code is ignored
        src.pulse(2);
        repeat (20) @(posedge ref_clk);
        rd(frame_fifo_pkg::ADDR_FRAME_CTRL);
        chk("ack while mode 11", 8'h00, v & 8'h08);
        wr(frame_fifo_pkg::ADDR_INTERP, 8'h00);
        wr(frame_fifo_pkg::ADDR_LEVEL_REQ, 8'h41);
        rd(frame_fifo_pkg::ADDR_LEVEL_REQ);
        chk("level request", 8'h41, v);
        // one link period is too short in byte mode
        // strap must pass the link synchroniser before the pulse
        byte_mode <= 1'b1;
        repeat (10) @(posedge ref_clk);
        wr(frame_fifo_pkg::ADDR_FRAME_CTRL, 8'h00);
        src.pulse(1);
        repeat (20) @(posedge ref_clk);
        rd(frame_fifo_pkg::ADDR_FRAME_CTRL);
        chk("short pulse", 8'h00, v);
        two_pulse(8'h04, 8'h01);
        two_pulse(8'h00, 8'h00);
        // free-running frame also starts a reset
        wr(frame_fifo_pkg::ADDR_FRAME_CTRL, 8'h00);
        periodic <= 1'b1;
        wait_ack;
        periodic <= 1'b0;
        // one read step every two core cycles at 2x, no resets now
        n = 0;
        repeat (20) begin
            @(posedge ref_clk);
            #1;
            n += sample_valid;
        end
        chk("sample rate", 8'h0a, n[7:0]);
        // the drifting depth sweeps every slot; only set a latches
        wr(frame_fifo_pkg::ADDR_IRQ_EN_A, 8'h07);
        repeat (60) @(posedge ref_clk);
        rd(frame_fifo_pkg::ADDR_STATUS);
        chk("latched flags", 8'h07, v & 8'h07);
        chk("irq a", 8'h00, {7'h00, interrupt_out_a_n});
        chk("irq b masked", 8'h01, {7'h00, interrupt_out_b_n});
        wr(frame_fifo_pkg::ADDR_IRQ_EN_A, 8'h00);
        wr(frame_fifo_pkg::ADDR_STATUS, 8'h07);
        rd(frame_fifo_pkg::ADDR_STATUS);
        chk("flags cleared", 8'h00, v & 8'h07);
        chk("irq a released", 8'h01, {7'h00, interrupt_out_a_n});
        wr(frame_fifo_pkg::ADDR_IRQ_EN_B, 8'h01);
        repeat (60) @(posedge ref_clk);
        rd(frame_fifo_pkg::ADDR_STATUS);
        chk("flags via b", 8'h01, v & 8'h07);
        chk("irq b", 8'h00, {7'h00, interrupt_out_b_n});
        end_of_test;
    end

    // the sequence needs about 400 core cycles
    initial begin
        #100us;
        num_errors++;
        end_of_test;
    end
endmodule
`default_nettype wire
